// *** include/mcu_ls_consts.svh ***
// Constants of the load/store and 16-bit word executor: cycle counts
// and reset values. Assumes it is included by its bare name.
`ifndef MCU_LS_CONSTS_SVH
`define MCU_LS_CONSTS_SVH
// Functional notes
// - E4 writes immediate to page byte, 5 cycles.
// - DB loads A from (X), then X+1.
// - FB stores A to (X), then X+1.
// - E5 stores A to page, 4 cycles.
// - X stores: EC page, ED page+Y, FC absolute.
// - Y stores: E9 page, F9 page+X, F8 absolute.
// - E8 copies A to X, sets N Z.
// - 9F copies A to Y, sets N Z.
// - AE copies SP to X, sets N Z.
// - C8 copies X to A, sets N Z.
// - 8E copies X to SP, sets N Z.
// - BF copies Y to A, sets N Z.
// - EE swaps X and A, flags kept.
// - DE swaps Y and A, flags kept.
// - BC, AD, BB swap memory with A, N Z.
// - FE swaps X and Y, flags kept.
// - 1D adds page word to Y:A pair.
// - 3D subtracts page word from Y:A pair.
// - 5D compares Y:A with word, N Z C only.
// - BD decrements page word, sets N Z.
// - 9D increments page word, sets N Z.

// Cycle counts, issue cycle included
`define CYC_XFER    3'h2
`define CYC_LD_IMM  3'h2
`define CYC_LD_PG   3'h3
`define CYC_LD_IDX  3'h4
`define CYC_LD_ABSY 3'h5
`define CYC_ST_PG   3'h4
`define CYC_ST_IDX  3'h5
`define CYC_ST_ABSY 3'h6
`define CYC_LDM     3'h5
`define CYC_SWAP    3'h4
`define CYC_XMA_PG  3'h5
`define CYC_XMA_PGX 3'h6
`define CYC_XMA_IX  3'h5
`define CYC_WORD    3'h5
`define CYC_WCMP    3'h4
`define CYC_WRMW    3'h6

// Reset values
`define RST_BYTE    8'h00
`define RST_SP      8'h00
`define RST_ADDR    16'h0000
`endif

// *** include/mcu_ls_pkg.sv ***
// Types and opcode decode table of the load/store word executor.
// Assumes the constants header is on the include path.
`default_nettype none
`include "mcu_ls_consts.svh"

package mcu_ls_pkg;
	// ==========================================================
	// Types
	typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} state_e;
	typedef enum logic [3:0] {
		CL_XFER = 4'h0, CL_SWAP = 4'h1, CL_LDIMM = 4'h2,
		CL_LDMEM = 4'h3, CL_STORE = 4'h4, CL_LDM = 4'h5,
		CL_XMA = 4'h6, CL_WADD = 4'h7, CL_WSUB = 4'h8,
		CL_WCMP = 4'h9, CL_WLD = 4'hA, CL_WINC = 4'hB,
		CL_WDEC = 4'hC, CL_WST = 4'hD
	} class_e;
	typedef enum logic [2:0] {
		AM_NONE = 3'h0, AM_PG = 3'h1, AM_PGX = 3'h2, AM_PGY = 3'h3,
		AM_ABS = 3'h4, AM_ABSY = 3'h5, AM_IX = 3'h6, AM_IXINC = 3'h7
	} amode_e;
	typedef enum logic [1:0] {
		R_ACC = 2'h0, R_X = 2'h1, R_Y = 2'h2, R_SP = 2'h3
	} reg_e;
	typedef enum logic [2:0] {
		MO_NONE = 3'h0, MO_RDLO = 3'h1, MO_RDHI = 3'h2,
		MO_WRLO = 3'h3, MO_WRHI = 3'h4
	} memop_e;
	typedef struct packed {
		logic       ok;
		class_e     cls;
		amode_e     am;
		reg_e       src;
		reg_e       dst;
		logic [2:0] cyc;
	} decode_s;

	// ==========================================================
	// Decode helpers
	function automatic decode_s mk(class_e c, amode_e a, reg_e s,
		reg_e d, logic [2:0] n);
		mk = '{ok: 1'b1, cls: c, am: a, src: s, dst: d, cyc: n};
	endfunction

	// Opcode table; in the executor each opcode value lives here and nowhere else
	function automatic decode_s decode(input logic [7:0] op);
		decode_s r;
		r = '0;
		case (op)
		8'hC4: r = mk(CL_LDIMM, AM_NONE, R_ACC, R_ACC, `CYC_LD_IMM);
		8'hC5: r = mk(CL_LDMEM, AM_PG, R_ACC, R_ACC, `CYC_LD_PG);
		8'hC6: r = mk(CL_LDMEM, AM_PGX, R_ACC, R_ACC, `CYC_LD_IDX);
		8'hC7: r = mk(CL_LDMEM, AM_ABS, R_ACC, R_ACC, `CYC_LD_IDX);
		8'hD5: r = mk(CL_LDMEM, AM_ABSY, R_ACC, R_ACC, `CYC_LD_ABSY);
		8'hD4: r = mk(CL_LDMEM, AM_IX, R_ACC, R_ACC, `CYC_LD_PG);
		8'hDB: r = mk(CL_LDMEM, AM_IXINC, R_ACC, R_ACC, `CYC_LD_IDX);
		8'hE4: r = mk(CL_LDM, AM_PG, R_ACC, R_ACC, `CYC_LDM);
		8'h1E: r = mk(CL_LDIMM, AM_NONE, R_X, R_X, `CYC_LD_IMM);
		8'hCC: r = mk(CL_LDMEM, AM_PG, R_X, R_X, `CYC_LD_PG);
		8'hCD: r = mk(CL_LDMEM, AM_PGY, R_X, R_X, `CYC_LD_IDX);
		8'hDC: r = mk(CL_LDMEM, AM_ABS, R_X, R_X, `CYC_LD_IDX);
		8'h3E: r = mk(CL_LDIMM, AM_NONE, R_Y, R_Y, `CYC_LD_IMM);
		8'hC9: r = mk(CL_LDMEM, AM_PG, R_Y, R_Y, `CYC_LD_PG);
		8'hD9: r = mk(CL_LDMEM, AM_PGX, R_Y, R_Y, `CYC_LD_IDX);
		8'hD8: r = mk(CL_LDMEM, AM_ABS, R_Y, R_Y, `CYC_LD_IDX);
		8'hE5: r = mk(CL_STORE, AM_PG, R_ACC, R_ACC, `CYC_ST_PG);
		8'hE6: r = mk(CL_STORE, AM_PGX, R_ACC, R_ACC, `CYC_ST_IDX);
		8'hE7: r = mk(CL_STORE, AM_ABS, R_ACC, R_ACC, `CYC_ST_IDX);
		8'hF5: r = mk(CL_STORE, AM_ABSY, R_ACC, R_ACC, `CYC_ST_ABSY);
		8'hFB: r = mk(CL_STORE, AM_IXINC, R_ACC, R_ACC, `CYC_ST_PG);
		8'hEC: r = mk(CL_STORE, AM_PG, R_X, R_X, `CYC_ST_PG);
		8'hED: r = mk(CL_STORE, AM_PGY, R_X, R_X, `CYC_ST_IDX);
		8'hFC: r = mk(CL_STORE, AM_ABS, R_X, R_X, `CYC_ST_IDX);
		8'hE9: r = mk(CL_STORE, AM_PG, R_Y, R_Y, `CYC_ST_PG);
		8'hF9: r = mk(CL_STORE, AM_PGX, R_Y, R_Y, `CYC_ST_IDX);
		8'hF8: r = mk(CL_STORE, AM_ABS, R_Y, R_Y, `CYC_ST_IDX);
		8'hE8: r = mk(CL_XFER, AM_NONE, R_ACC, R_X, `CYC_XFER);
		8'h9F: r = mk(CL_XFER, AM_NONE, R_ACC, R_Y, `CYC_XFER);
		8'hAE: r = mk(CL_XFER, AM_NONE, R_SP, R_X, `CYC_XFER);
		8'hC8: r = mk(CL_XFER, AM_NONE, R_X, R_ACC, `CYC_XFER);
		8'h8E: r = mk(CL_XFER, AM_NONE, R_X, R_SP, `CYC_XFER);
		8'hBF: r = mk(CL_XFER, AM_NONE, R_Y, R_ACC, `CYC_XFER);
		8'hEE: r = mk(CL_SWAP, AM_NONE, R_X, R_ACC, `CYC_SWAP);
		8'hDE: r = mk(CL_SWAP, AM_NONE, R_Y, R_ACC, `CYC_SWAP);
		8'hFE: r = mk(CL_SWAP, AM_NONE, R_X, R_Y, `CYC_SWAP);
		8'hBC: r = mk(CL_XMA, AM_PG, R_ACC, R_ACC, `CYC_XMA_PG);
		8'hAD: r = mk(CL_XMA, AM_PGX, R_ACC, R_ACC, `CYC_XMA_PGX);
		8'hBB: r = mk(CL_XMA, AM_IX, R_ACC, R_ACC, `CYC_XMA_IX);
		8'h1D: r = mk(CL_WADD, AM_PG, R_ACC, R_ACC, `CYC_WORD);
		8'h3D: r = mk(CL_WSUB, AM_PG, R_ACC, R_ACC, `CYC_WORD);
		8'h5D: r = mk(CL_WCMP, AM_PG, R_ACC, R_ACC, `CYC_WCMP);
		8'hBD: r = mk(CL_WDEC, AM_PG, R_ACC, R_ACC, `CYC_WRMW);
		8'h9D: r = mk(CL_WINC, AM_PG, R_ACC, R_ACC, `CYC_WRMW);
		8'h7D: r = mk(CL_WLD, AM_PG, R_ACC, R_ACC, `CYC_WORD);
		8'hDD: r = mk(CL_WST, AM_PG, R_ACC, R_ACC, `CYC_WORD);
		default: r = '0;
		endcase
		return r;
	endfunction

	// Memory action for step s of an instruction ending at step last
	function automatic memop_e plan(class_e c, logic [2:0] s,
		logic [2:0] last);
		logic rd;
		logic wd;
		logic one;
		logic pair;
		rd = c inside {CL_LDMEM, CL_XMA, CL_WADD, CL_WSUB, CL_WCMP,
			CL_WLD, CL_WINC, CL_WDEC};
		wd = c inside {CL_WADD, CL_WSUB, CL_WCMP, CL_WLD, CL_WINC,
			CL_WDEC};
		one = c inside {CL_STORE, CL_LDM, CL_XMA};
		pair = c inside {CL_WINC, CL_WDEC, CL_WST};
		if (s == 3'h1 && rd)
			plan = MO_RDLO;
		else if (s == 3'h2 && wd)
			plan = MO_RDHI;
		else if (s == last && one)
			plan = MO_WRLO;
		else if (s == last - 3'h1 && pair)
			plan = MO_WRLO;
		else if (s == last && pair)
			plan = MO_WRHI;
		else
			plan = MO_NONE;
	endfunction
endpackage
`default_nettype wire

// *** logic/mcu_load_store_word_ops.sv ***
// Executor for the register/memory transfer and 16-bit word
// instructions of an 8-bit core; owns A, X, Y, SP and N V H Z C.
// Assumes a synchronous data memory with one cycle read latency.
`timescale 1ns/10ps
`default_nettype none
`include "mcu_ls_consts.svh"

module mcu_load_store_word_ops (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        issueValid,
	input  wire logic [7:0]  issueOpcode,
	input  wire logic [7:0]  issueOperand1,
	input  wire logic [7:0]  issueOperand2,
	input  wire logic        pageSel,
	input  wire logic [7:0]  memRdData,
	output logic             busy,
	output logic             done,
	output logic             illegalOp,
	output logic [15:0]      memAddr,
	output logic [7:0]       memWrData,
	output logic             memRe,
	output logic             memWe,
	output logic [7:0]       acc,
	output logic [7:0]       idxX,
	output logic [7:0]       idxY,
	output logic [7:0]       stackPtr,
	output logic             flagN,
	output logic             flagV,
	output logic             flagH,
	output logic             flagZ,
	output logic             flagC
);
	// ==========================================================
	// Declarations
	mcu_ls_pkg::state_e   state_reg;   // Idle or executing
	mcu_ls_pkg::class_e   cls_reg;     // Class of running op
	mcu_ls_pkg::amode_e   am_reg;      // Its addressing mode
	mcu_ls_pkg::reg_e     src_reg;     // Source register
	mcu_ls_pkg::reg_e     dst_reg;     // Destination register
	mcu_ls_pkg::decode_s  dIn;         // Decode of issued opcode
	mcu_ls_pkg::memop_e   mo;          // Memory action next cycle
	mcu_ls_pkg::class_e   planCls;     // Class seen by planner
	logic [2:0]  step_reg;             // Cycle within instruction
	logic [2:0]  last_reg;             // Final step number
	logic [2:0]  planStep;             // Step about to start
	logic [2:0]  planLast;             // Final step for planner
	logic [7:0]  op1_reg;              // First operand byte
	logic [7:0]  op2_reg;              // Second operand byte
	logic [15:0] ea_reg;               // Effective address
	logic [15:0] eaIn;                 // Address formed at issue
	logic [15:0] eaCur;                // Address for planner
	logic [15:0] eaPair;               // Address of high byte
	logic [7:0]  lo_reg;               // Captured low byte
	logic [7:0]  hi_reg;               // Captured high byte
	logic [7:0]  rdLo;                 // Low byte, live or held
	logic [7:0]  rdHi;                 // High byte, live or held
	logic [7:0]  pageHi;               // Direct page high byte
	logic        take;                 // Issue accepted
	logic        finish;               // Last step of instruction
	logic [7:0]  wrData;               // Data for next write
	logic [7:0]  acc_reg, acc_next;
	logic [7:0]  x_reg, x_next;
	logic [7:0]  y_reg, y_next;
	logic [7:0]  sp_reg, sp_next;
	logic        n_reg, n_next;
	logic        v_reg, v_next;
	logic        h_reg, h_next;
	logic        z_reg, z_next;
	logic        c_reg, c_next;
	logic        busy_reg;
	logic        done_reg;
	logic        illegal_reg;
	logic [15:0] memAddr_reg;
	logic [7:0]  memWrData_reg;
	logic        memRe_reg;
	logic        memWe_reg;
	// Word arithmetic
	logic [15:0] word;                 // Memory pair, high:low
	logic [15:0] pairYA;               // Y:A pair
	logic [16:0] sum17;                // Pair plus word
	logic [16:0] diff17;               // Pair minus word
	logic [12:0] half13;               // Low twelve bits added
	logic [15:0] wordInc;              // Word plus one
	logic [15:0] wordDec;              // Word minus one
	// Register write ports used at the last step
	logic        dstWe;
	logic        srcWe;
	logic [7:0]  dstVal;
	logic [7:0]  srcVal;

	// ==========================================================
	// Helpers
	// Reads one of the four programmer registers
	function automatic logic [7:0] pick(mcu_ls_pkg::reg_e r);
		case (r)
		mcu_ls_pkg::R_ACC: pick = acc_reg;
		mcu_ls_pkg::R_X:   pick = x_reg;
		mcu_ls_pkg::R_Y:   pick = y_reg;
		default:           pick = sp_reg;
		endcase
	endfunction

	// ==========================================================
	// Issue and sequencing
	assign dIn = mcu_ls_pkg::decode(issueOpcode);
	// Opcodes outside this block are refused, never half executed
	assign take = issueValid && state_reg == mcu_ls_pkg::ST_IDLE
		&& dIn.ok;
	assign finish = state_reg == mcu_ls_pkg::ST_RUN
		&& step_reg == last_reg;
	assign pageHi = {7'h00, pageSel};

	// Effective address from the operands and current indexes
	always_comb begin
		case (dIn.am)
		mcu_ls_pkg::AM_PG:    eaIn = {pageHi, issueOperand1};
		mcu_ls_pkg::AM_PGX:   eaIn = {pageHi,
			8'(issueOperand1 + x_reg)};
		mcu_ls_pkg::AM_PGY:   eaIn = {pageHi,
			8'(issueOperand1 + y_reg)};
		mcu_ls_pkg::AM_ABS:   eaIn = {issueOperand2, issueOperand1};
		mcu_ls_pkg::AM_ABSY:  eaIn = {issueOperand2, issueOperand1}
			+ {8'h00, y_reg};
		mcu_ls_pkg::AM_IX,
		mcu_ls_pkg::AM_IXINC: eaIn = {pageHi, x_reg};
		default:              eaIn = `RST_ADDR;
		endcase
	end

	// Sequencer: step 1 follows the issue edge, commit at last step
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= mcu_ls_pkg::ST_IDLE;
			step_reg <= 3'h0;
			last_reg <= 3'h0;
			cls_reg <= mcu_ls_pkg::CL_XFER;
			am_reg <= mcu_ls_pkg::AM_NONE;
			src_reg <= mcu_ls_pkg::R_ACC;
			dst_reg <= mcu_ls_pkg::R_ACC;
			op1_reg <= `RST_BYTE;
			op2_reg <= `RST_BYTE;
			ea_reg <= `RST_ADDR;
			busy_reg <= 1'b0;
		end else if (take) begin
			state_reg <= mcu_ls_pkg::ST_RUN;
			step_reg <= 3'h1;
			last_reg <= dIn.cyc - 3'h1;
			cls_reg <= dIn.cls;
			am_reg <= dIn.am;
			src_reg <= dIn.src;
			dst_reg <= dIn.dst;
			op1_reg <= issueOperand1;
			op2_reg <= issueOperand2;
			ea_reg <= eaIn;
			busy_reg <= 1'b1;
		end else if (finish) begin
			state_reg <= mcu_ls_pkg::ST_IDLE;
			step_reg <= 3'h0;
			busy_reg <= 1'b0;
		end else if (state_reg == mcu_ls_pkg::ST_RUN) begin
			step_reg <= step_reg + 3'h1;
		end
	end

	// Completion and refusal pulses
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			done_reg <= 1'b0;
			illegal_reg <= 1'b0;
		end else begin
			done_reg <= finish;
			illegal_reg <= issueValid && !dIn.ok
				&& state_reg == mcu_ls_pkg::ST_IDLE;
		end
	end

	// ==========================================================
	// Read capture
	// Memory answers one cycle after the read strobe
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lo_reg <= `RST_BYTE;
			hi_reg <= `RST_BYTE;
		end else if (state_reg == mcu_ls_pkg::ST_RUN) begin
			if (step_reg == 3'h2)
				lo_reg <= memRdData;
			if (step_reg == 3'h3)
				hi_reg <= memRdData;
		end
	end
	// Bytes are live in their arrival step, held afterwards
	assign rdLo = step_reg == 3'h2 ? memRdData : lo_reg;
	assign rdHi = step_reg == 3'h3 ? memRdData : hi_reg;

	// ==========================================================
	// Word arithmetic
	assign word = {rdHi, rdLo};
	assign pairYA = {y_reg, acc_reg};
	assign sum17 = {1'b0, pairYA} + {1'b0, word};
	assign diff17 = {1'b0, pairYA} - {1'b0, word};
	assign half13 = {1'b0, pairYA[11:0]} + {1'b0, word[11:0]};
	assign wordInc = word + 16'h0001;
	assign wordDec = word - 16'h0001;

	// ==========================================================
	// Memory port
	// Planned one step ahead so strobes leave straight from flops
	assign planStep = take ? 3'h1 : step_reg + 3'h1;
	assign planCls = take ? dIn.cls : cls_reg;
	assign planLast = take ? dIn.cyc - 3'h1 : last_reg;
	assign mo = (take || (state_reg == mcu_ls_pkg::ST_RUN && !finish))
		? mcu_ls_pkg::plan(planCls, planStep, planLast)
		: mcu_ls_pkg::MO_NONE;
	assign eaCur = take ? eaIn : ea_reg;
	// High byte wraps inside the page of the low byte
	assign eaPair = {eaCur[15:8], 8'(eaCur[7:0] + 8'h01)};

	// Data for the write about to be made
	always_comb begin
		wrData = acc_reg;
		case (planCls)
		mcu_ls_pkg::CL_STORE: wrData = pick(src_reg);
		mcu_ls_pkg::CL_LDM:   wrData = op2_reg;
		mcu_ls_pkg::CL_WINC:  wrData = mo == mcu_ls_pkg::MO_WRHI
			? wordInc[15:8] : wordInc[7:0];
		mcu_ls_pkg::CL_WDEC:  wrData = mo == mcu_ls_pkg::MO_WRHI
			? wordDec[15:8] : wordDec[7:0];
		mcu_ls_pkg::CL_WST:   wrData = mo == mcu_ls_pkg::MO_WRHI
			? y_reg : acc_reg;
		default:              wrData = acc_reg;
		endcase
	end

	// Strobes, address and write data
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			memRe_reg <= 1'b0;
			memWe_reg <= 1'b0;
			memAddr_reg <= `RST_ADDR;
			memWrData_reg <= `RST_BYTE;
		end else begin
			memRe_reg <= mo == mcu_ls_pkg::MO_RDLO
				|| mo == mcu_ls_pkg::MO_RDHI;
			memWe_reg <= mo == mcu_ls_pkg::MO_WRLO
				|| mo == mcu_ls_pkg::MO_WRHI;
			if (mo == mcu_ls_pkg::MO_RDHI || mo == mcu_ls_pkg::MO_WRHI)
				memAddr_reg <= eaPair;
			else if (mo != mcu_ls_pkg::MO_NONE)
				memAddr_reg <= eaCur;
			memWrData_reg <= wrData;
		end
	end

	// ==========================================================
	// Register and flag results
	always_comb begin
		acc_next = acc_reg;
		x_next = x_reg;
		y_next = y_reg;
		sp_next = sp_reg;
		n_next = n_reg;
		v_next = v_reg;
		h_next = h_reg;
		z_next = z_reg;
		c_next = c_reg;
		dstWe = 1'b0;
		srcWe = 1'b0;
		dstVal = rdLo;
		srcVal = pick(dst_reg);
		if (finish) begin
			case (cls_reg)
			mcu_ls_pkg::CL_LDIMM,
			mcu_ls_pkg::CL_LDMEM: begin
				dstWe = 1'b1;
				dstVal = cls_reg == mcu_ls_pkg::CL_LDIMM
					? op1_reg : rdLo;
				n_next = dstVal[7];
				z_next = dstVal == 8'h00;
			end
			mcu_ls_pkg::CL_XFER: begin
				dstWe = 1'b1;
				dstVal = pick(src_reg);
				n_next = dstVal[7];
				z_next = dstVal == 8'h00;
			end
			mcu_ls_pkg::CL_SWAP: begin
				// Both halves commit on one edge, flags untouched
				dstWe = 1'b1;
				srcWe = 1'b1;
				dstVal = pick(src_reg);
			end
			mcu_ls_pkg::CL_XMA: begin
				acc_next = rdLo;
				n_next = rdLo[7];
				z_next = rdLo == 8'h00;
			end
			mcu_ls_pkg::CL_WADD: begin
				{y_next, acc_next} = sum17[15:0];
				c_next = sum17[16];
				h_next = half13[12];
				v_next = pairYA[15] == word[15]
					&& sum17[15] != pairYA[15];
				n_next = sum17[15];
				z_next = sum17[15:0] == 16'h0000;
			end
			mcu_ls_pkg::CL_WSUB,
			mcu_ls_pkg::CL_WCMP: begin
				// Carry set means no borrow
				c_next = !diff17[16];
				n_next = diff17[15];
				z_next = diff17[15:0] == 16'h0000;
				if (cls_reg == mcu_ls_pkg::CL_WSUB) begin
					{y_next, acc_next} = diff17[15:0];
					h_next = pairYA[11:0] >= word[11:0];
					v_next = pairYA[15] != word[15]
						&& diff17[15] != pairYA[15];
				end
			end
			mcu_ls_pkg::CL_WINC: begin
				n_next = wordInc[15];
				z_next = wordInc == 16'h0000;
			end
			mcu_ls_pkg::CL_WDEC: begin
				n_next = wordDec[15];
				z_next = wordDec == 16'h0000;
			end
			mcu_ls_pkg::CL_WLD: begin
				{y_next, acc_next} = word;
				n_next = word[15];
				z_next = word == 16'h0000;
			end
			default: begin
				// Stores and immediate-to-memory keep all flags
				dstWe = 1'b0;
			end
			endcase
			if (dstWe) begin
				case (dst_reg)
				mcu_ls_pkg::R_ACC: acc_next = dstVal;
				mcu_ls_pkg::R_X:   x_next = dstVal;
				mcu_ls_pkg::R_Y:   y_next = dstVal;
				default:           sp_next = dstVal;
				endcase
			end
			if (srcWe) begin
				case (src_reg)
				mcu_ls_pkg::R_ACC: acc_next = srcVal;
				mcu_ls_pkg::R_X:   x_next = srcVal;
				mcu_ls_pkg::R_Y:   y_next = srcVal;
				default:           sp_next = srcVal;
				endcase
			end
			// Post increment after the access through X
			if (am_reg == mcu_ls_pkg::AM_IXINC)
				x_next = x_reg + 8'h01;
		end
	end

	// Programmer registers and flags
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			acc_reg <= `RST_BYTE;
			x_reg <= `RST_BYTE;
			y_reg <= `RST_BYTE;
			sp_reg <= `RST_SP;
			{n_reg, v_reg, h_reg, z_reg, c_reg} <= 5'h00;
		end else begin
			acc_reg <= acc_next;
			x_reg <= x_next;
			y_reg <= y_next;
			sp_reg <= sp_next;
			{n_reg, v_reg, h_reg, z_reg, c_reg} <=
				{n_next, v_next, h_next, z_next, c_next};
		end
	end

	// ==========================================================
	// Outputs, each straight from a flop
	assign busy = busy_reg;
	assign done = done_reg;
	assign illegalOp = illegal_reg;
	assign memAddr = memAddr_reg;
	assign memWrData = memWrData_reg;
	assign memRe = memRe_reg;
	assign memWe = memWe_reg;
	assign acc = acc_reg;
	assign idxX = x_reg;
	assign idxY = y_reg;
	assign stackPtr = sp_reg;
	assign flagN = n_reg;
	assign flagV = v_reg;
	assign flagH = h_reg;
	assign flagZ = z_reg;
	assign flagC = c_reg;
endmodule
`default_nettype wire

// *** bench/mcu_ls_checker.sv ***
// Concurrent checks on the ports of the load/store word executor.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module mcu_ls_checker (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       issueValid,
	input wire logic [7:0] issueOpcode,
	input wire logic [7:0] issueOperand2,
	input wire logic       busy,
	input wire logic       done,
	input wire logic       illegalOp,
	input wire logic [7:0] memWrData,
	input wire logic       memWe,
	input wire logic       memRe,
	input wire logic [7:0] acc,
	input wire logic [7:0] idxX,
	input wire logic [7:0] idxY,
	input wire logic       flagV
);
	// ==========================================================
	// Sequences
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Request taken with a given opcode
	sequence s_take(logic [7:0] op);
		issueValid && !busy && issueOpcode == op;
	endsequence
	// Low then high byte written, then completion
	sequence s_pair_wr;
		memWe [*2] ##1 done;
	endsequence
	// ==========================================================
	// Assertions
	a_ldm_write: assert property (
		s_take(8'hE4) |-> ##4 memWe && memWrData ==
		$past(issueOperand2, 4) ##1 done) else $error("fill wrong");
	a_load_xinc: assert property (
		s_take(8'hDB) |-> ##4 done && idxX == $past(idxX, 4) + 8'h01)
		else $error("X step wrong");
	a_store_page: assert property (
		s_take(8'hE5) |-> ##3 memWe && memWrData == $past(acc, 3)
		##1 done) else $error("page store wrong");
	a_copy_x: assert property (
		s_take(8'hE8) |-> ##2 done && idxX == $past(acc, 2))
		else $error("copy to X wrong");
	a_swap_xa: assert property (
		s_take(8'hEE) |-> ##4 done && acc == $past(idxX, 4) &&
		idxX == $past(acc, 4)) else $error("swap wrong");
	a_wcmp_keep: assert property (
		s_take(8'h5D) |-> ##4 done && acc == $past(acc, 4) &&
		idxY == $past(idxY, 4) && flagV == $past(flagV, 4))
		else $error("compare changed state");
	a_word_rmw: assert property (
		(s_take(8'h9D) or s_take(8'hBD)) |-> ##4 s_pair_wr)
		else $error("word update timing wrong");
	a_refuse_quiet: assert property (
		illegalOp |-> !done && !memWe && !memRe)
		else $error("refused opcode acted");
	a_busy_drop: assert property (
		$fell(busy) |-> done) else $error("busy fell without done");
endmodule
bind mcu_load_store_word_ops mcu_ls_checker mcu_ls_checker_i (.*);
`default_nettype wire

// *** bench/ram_model.sv ***
// Data memory beside the executor: synchronous, one cycle latency.
// Assumes address and strobes change only after rising edges.
`timescale 1ns/10ps
`default_nettype none
module ram_model (
	input wire logic        clk_sys,
	input wire logic [15:0] memAddr,
	input wire logic [7:0]  memWrData,
	input wire logic        memWe,
	input wire logic        memRe,
	output logic [7:0]      memRdData
);
	logic [7:0] mem [0:65535]; // Whole address space
	initial memRdData = 8'h00;
	// Read data valid only after a strobe; toggles otherwise so a
	// late sample never sees a stale byte
	always @(posedge clk_sys) begin
		if (memWe)
			mem[memAddr] <= memWrData;
		memRdData <= memRe ? mem[memAddr] : ~memRdData;
	end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench of the load/store word executor.
// Assumes the checker is bound and the memory model sits beside it.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk_sys = 0, rst = 1, issueValid = 0, pageSel = 0;
	logic [7:0]  issueOpcode = 0, issueOperand1 = 0, issueOperand2 = 0;
	logic [7:0]  memRdData, memWrData, acc, idxX, idxY, stackPtr;
	logic [15:0] memAddr;
	logic        busy, done, illegalOp, memRe, memWe;
	logic        flagN, flagV, flagH, flagZ, flagC;
	logic [4:0]  flg; // N V H Z C
	int          failures = 0, samplesChecked = 0;
	assign flg = {flagN, flagV, flagH, flagZ, flagC};
	always #5 clk_sys = ~clk_sys;
	mcu_load_store_word_ops mcu_load_store_word_ops_i (.*);
	ram_model ram_model_i (.*);
	// ==========================================================
	// Helpers
	task automatic chk(input logic [15:0] g, e);
		samplesChecked++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	// Issue one instruction, count cycles to done, check one result
	task automatic ex(input logic [7:0] o, a, b, input int n, w,
		input logic [15:0] e);
		int c;
		logic [15:0] v [6];
		@(negedge clk_sys);
		{issueValid, issueOpcode, issueOperand1, issueOperand2} = {1'b1, o, a, b};
		@(negedge clk_sys);
		issueValid = 0;
		c = 1;
		while (done !== 1'b1 && illegalOp !== 1'b1 && c < 9) begin
			@(negedge clk_sys);
			c++;
		end
		chk(16'(c), 16'(n));
		v = '{acc, idxX, idxY, stackPtr, flg, {idxY, acc}};
		if (w < 6)
			chk(v[w], e);
	endtask
	// ==========================================================
	// Scenarios
	task t_copies;
		ex(8'hC4, 8'h80, 0, 2, 4, 5'b10000);
		ex(8'hE8, 0, 0, 2, 1, 8'h80);
		ex(8'h9F, 0, 0, 2, 2, 8'h80);
		ex(8'h8E, 0, 0, 2, 3, 8'h80);
		ex(8'h1E, 8'h00, 0, 2, 4, 5'b00010);
		ex(8'hAE, 0, 0, 2, 1, 8'h80);
		ex(8'hC4, 8'h00, 0, 2, 0, 8'h00);
		ex(8'hC8, 0, 0, 2, 0, 8'h80);
		ex(8'hC4, 8'h00, 0, 2, 0, 8'h00);
		ex(8'hBF, 0, 0, 2, 4, 5'b10000);
	endtask
	task t_swaps;
		ex(8'hC4, 8'h11, 0, 2, 0, 8'h11);
		ex(8'h1E, 8'h22, 0, 2, 1, 8'h22);
		ex(8'h3E, 8'h80, 0, 2, 4, 5'b10000);
		ex(8'hEE, 0, 0, 4, 4, 5'b10000);
		ex(8'hDE, 0, 0, 4, 0, 8'h80);
		ex(8'hFE, 0, 0, 4, 2, 8'h11);
	endtask
	// Starts with A 80, X 22, Y 11
	task t_stores;
		ex(8'hE5, 8'h40, 0, 4, 6, 0);
		chk(ram_model_i.mem[16'h0040], 8'h80);
		ex(8'hE4, 8'h41, 8'h5A, 5, 4, 5'b10000);
		chk(ram_model_i.mem[16'h0041], 8'h5A);
		pageSel = 1;
		ex(8'hEC, 8'h10, 0, 4, 6, 0);
		chk(ram_model_i.mem[16'h0110], 8'h22);
		ex(8'hED, 8'hF8, 0, 5, 6, 0);
		chk(ram_model_i.mem[16'h0109], 8'h22);
		ex(8'hFC, 8'h34, 8'h12, 5, 6, 0);
		chk(ram_model_i.mem[16'h1234], 8'h22);
		ex(8'hE9, 8'h20, 0, 4, 6, 0);
		chk(ram_model_i.mem[16'h0120], 8'h11);
		ex(8'hF9, 8'hF0, 0, 5, 6, 0);
		chk(ram_model_i.mem[16'h0112], 8'h11);
		ex(8'hF8, 8'h78, 8'h56, 5, 6, 0);
		chk(ram_model_i.mem[16'h5678], 8'h11);
		ex(8'hFB, 0, 0, 4, 1, 8'h23);
		chk(ram_model_i.mem[16'h0122], 8'h80);
		ram_model_i.mem[16'h0123] = 8'h3C;
		ex(8'hDB, 0, 0, 4, 0, 8'h3C);
		pageSel = 0;
	endtask
	// Starts with A 3C, X 24
	task t_xma;
		ram_model_i.mem[16'h0050] = 8'hC3;
		ram_model_i.mem[16'h0074] = 8'h00;
		ram_model_i.mem[16'h0024] = 8'h7F;
		ex(8'hBC, 8'h50, 0, 5, 4, 5'b10000);
		chk(ram_model_i.mem[16'h0050], 8'h3C);
		ex(8'hAD, 8'h50, 0, 6, 4, 5'b00010);
		chk(ram_model_i.mem[16'h0074], 8'hC3);
		ex(8'hBB, 0, 0, 5, 0, 8'h7F);
	endtask
	// Starts with A 7F, X 24, Y 11; byte 0024 holds 00
	task t_loads;
		{ram_model_i.mem[16'h0031], ram_model_i.mem[16'h0030]} = 16'h4281;
		ram_model_i.mem[16'h1201] = 8'h5C;
		ex(8'hD5, 8'hF0, 8'h11, 5, 0, 8'h5C);
		ex(8'hD4, 0, 0, 3, 4, 5'b00010);
		ex(8'hC5, 8'h30, 0, 3, 4, 5'b10000);
		ex(8'hC7, 8'h34, 8'h12, 4, 0, 8'h22);
		ex(8'hC6, 8'h0D, 0, 4, 0, 8'h42);
		ex(8'hCD, 8'h20, 0, 4, 1, 8'h42);
		ex(8'hCC, 8'h30, 0, 3, 1, 8'h81);
		ex(8'hD9, 8'hB0, 0, 4, 2, 8'h42);
		ex(8'hC9, 8'h30, 0, 3, 2, 8'h81);
		ex(8'hD8, 8'h01, 8'h12, 4, 2, 8'h5C);
		ex(8'hDC, 8'h34, 8'h12, 4, 1, 8'h22);
		// Stores of A 42 with X 22 and Y 5C
		ex(8'hE6, 8'h10, 0, 5, 6, 0);
		chk(ram_model_i.mem[16'h0032], 8'h42);
		ex(8'hE7, 8'h40, 8'h12, 5, 6, 0);
		chk(ram_model_i.mem[16'h1240], 8'h42);
		ex(8'hF5, 8'hF0, 8'h11, 6, 6, 0);
		chk(ram_model_i.mem[16'h124C], 8'h42);
	endtask
	task t_word;
		{ram_model_i.mem[16'h0061], ram_model_i.mem[16'h0060]} = 16'h0FFF;
		{ram_model_i.mem[16'h0063], ram_model_i.mem[16'h0062]} = 16'h0000;
		ex(8'hC4, 8'h01, 0, 2, 0, 8'h01);
		ex(8'h3E, 8'h00, 0, 2, 2, 8'h00);
		ex(8'h1D, 8'h60, 0, 5, 5, 16'h1000);
		chk(flg, 5'b00100);
		ex(8'h3D, 8'h60, 0, 5, 5, 16'h0001);
		chk(flg, 5'b00001);
		ex(8'h5D, 8'h60, 0, 4, 4, 5'b10000);
		ex(8'h9D, 8'h60, 0, 6, 4, 5'b00000);
		chk(ram_model_i.mem[16'h0061], 8'h10);
		ex(8'hBD, 8'h62, 0, 6, 4, 5'b10000);
		chk(ram_model_i.mem[16'h0063], 8'hFF);
		ex(8'h7D, 8'h62, 0, 5, 5, 16'hFFFF);
		// Distinct halves so a swapped pair store shows
		ex(8'hC4, 8'h5A, 0, 2, 0, 8'h5A);
		ex(8'hDD, 8'h64, 0, 5, 6, 0);
		chk(ram_model_i.mem[16'h0064], 8'h5A);
		chk(ram_model_i.mem[16'h0065], 8'hFF);
		ex(8'hD6, 0, 0, 1, 5, 16'hFF5A);
	endtask
	// ==========================================================
	// Verdict, watchdog and main sequence
	task give_verdict;
		if (failures == 0 && samplesChecked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Whole run needs well under 1000 cycles
	initial begin
		repeat (3000) @(posedge clk_sys);
		failures++;
		give_verdict();
	end
	initial begin
		repeat (3) @(negedge clk_sys);
		rst = 0;
		t_copies();
		t_swaps();
		t_stores();
		t_xma();
		t_loads();
		t_word();
		give_verdict();
	end
endmodule
`default_nettype wire
